// >>> common/smc_pkg.sv
// Package for the sleep mode controller: register map, fields, timing
package smc_pkg;

	// Register map, byte addresses on the Wishbone bus
	localparam logic [3:0] SMC_ADDR_CTRL = 4'h0;
	localparam logic [3:0] SMC_ADDR_STAT = 4'h4;

	// Control register fields
	localparam int SMC_SE_BIT = 5;
	localparam int SMC_SM_LSB = 2;
	localparam logic [7:0] SMC_CTRL_RST = 8'h00;

	// Timing in main clock cycles
	localparam logic [3:0] SMC_INT_STALL = 4'h4;
	localparam logic [3:0] SMC_STBY_WAKE = 4'h6;
	localparam logic [15:0] SMC_STARTUP_DFLT = 16'h0006;

	// Sleep mode codes
	typedef enum logic [2:0] {
		SMC_IDLE = 3'b000,
		SMC_NOISE = 3'b001,
		SMC_PDOWN = 3'b010,
		SMC_PSAVE = 3'b011,
		SMC_RSV4 = 3'b100,
		SMC_RSV5 = 3'b101,
		SMC_STBY = 3'b110,
		SMC_XSTBY = 3'b111
	} smc_mode_t;

	// Controller states
	typedef enum logic [1:0] {
		SMC_RUN = 2'b00,
		SMC_SLEEP = 2'b01,
		SMC_START = 2'b10,
		SMC_STALL = 2'b11
	} smc_state_t;

	// Wake-up sources
	typedef struct packed {
		logic adc_done;
		logic twi_match;
		logic timer0;
		logic spm_ready;
		logic other_io;
		logic [3:0] upper_ext_interrupts;
		logic [3:0] upper_level;
		logic [3:0] lower_ext_interrupts;
	} smc_wake_t;

	// Gated clock enables
	typedef struct packed {
		logic core_clock;
		logic program_memory_clock;
		logic io_clock;
		logic converter_clock;
		logic async_clock;
		logic main_osc;
		logic timer_osc;
	} smc_clk_t;

endpackage

// >>> logic/smc_sleep_ctrl.sv
// Sleep mode controller with Wishbone control register
// Overview of operation
// - Sleep only when sleep_enable is set
// - Three-bit code selects six modes
// - Standby modes need crystal clock option
// - Idle stops core, program clocks, timer osc unless timer0 async
// - Idle wakes on any enabled interrupt
// - Converter starts on idle, noise entry
// - Noise mode stops io, core, program
// - Noise mode wake sources restricted
// - Power-down stops oscillator, generated clocks
// - Power-down wake sources restricted
// - Power-down start-up delay from fuses
// - Power-save keeps async timer0 waking
// - Power-save without async timer undefined
// - Standby keeps oscillator, wakes six cycles
// - Extended standby keeps oscillator, six cycles
// - Clock and wake table per mode
// - Interrupt wake stalls four extra cycles
// - Reset during sleep restarts from vector
//
// Local design decisions: the Wishbone slave port and the address map.
module smc_sleep_ctrl
(
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Core and sources
	input wire logic sleep_instr,
	input wire logic sleep_reset,
	input wire logic global_int_en,
	input wire logic timer0_async_clocking,
	input wire logic crystal_selected,
	input wire logic adc_enabled,
	input wire logic [15:0] startup_cycles,
	input wire smc_pkg::smc_wake_t wake_src,
	// Gated domains and events
	output smc_pkg::smc_clk_t clk_gate,
	output logic adc_start,
	output logic int_wake,
	output logic reset_wake,
	output logic async_undefined
);
	import smc_pkg::*;

	logic [7:0] ctrl_r;
	smc_state_t state_r;
	smc_mode_t mode_r;
	logic [15:0] cnt_r;
	logic by_int_r;
	smc_mode_t code;
	logic mode_ok;
	logic go_sleep;
	logic wake_any;
	logic wake_rst;
	logic wb_hit;
	smc_clk_t gate_nxt;

	assign code = smc_mode_t'(ctrl_r[SMC_SM_LSB+2:SMC_SM_LSB]);
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_comb
	begin
		unique case (code)
			SMC_IDLE, SMC_NOISE, SMC_PDOWN, SMC_PSAVE: mode_ok = 1'b1;
			SMC_STBY, SMC_XSTBY: mode_ok = crystal_selected;
			SMC_RSV4, SMC_RSV5: mode_ok = 1'b0;
		endcase
	end

	assign go_sleep = sleep_instr && ctrl_r[SMC_SE_BIT] && mode_ok;

	assign wake_rst = sleep_reset;

	always_comb
	begin
		wake_any = |wake_src.lower_ext_interrupts
			|| |(wake_src.upper_level) || wake_src.twi_match;
		unique case (mode_r)
			SMC_IDLE: wake_any = wake_any || wake_src.adc_done
				|| wake_src.timer0 || wake_src.spm_ready
				|| wake_src.other_io
				|| |wake_src.upper_ext_interrupts;
			SMC_NOISE: wake_any = wake_any || wake_src.adc_done
				|| wake_src.timer0 || wake_src.spm_ready;
			SMC_PSAVE, SMC_XSTBY: wake_any = wake_any
				|| (wake_src.timer0 && timer0_async_clocking
				&& global_int_en);
			default: wake_any = wake_any;
		endcase
	end

	// Wishbone register access, one wait-state ack
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ctrl_r <= SMC_CTRL_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else if (clk_en)
		begin
			wb_ack_o <= wb_hit;
			if (wb_hit && wb_we_i && wb_adr_i == SMC_ADDR_CTRL
				&& wb_sel_i[0])
				ctrl_r <= wb_dat_i[7:0];
			if (wb_hit && !wb_we_i)
			begin
				unique case (wb_adr_i)
					SMC_ADDR_CTRL: wb_dat_o <= {24'h0, ctrl_r};
					SMC_ADDR_STAT: wb_dat_o <= {27'h0, mode_r, state_r};
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// Sleep sequencer
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_r <= SMC_RUN;
			mode_r <= SMC_IDLE;
			cnt_r <= 16'h0;
			by_int_r <= 1'b0;
			int_wake <= 1'b0;
			reset_wake <= 1'b0;
		end
		else if (clk_en)
		begin
			int_wake <= 1'b0;
			reset_wake <= 1'b0;
			unique case (state_r)
				SMC_RUN:
					if (go_sleep)
					begin
						state_r <= SMC_SLEEP;
						mode_r <= code;
					end
				SMC_SLEEP:
					if (wake_rst)
					begin
						reset_wake <= 1'b1;
						state_r <= SMC_RUN;
					end
					else if (wake_any)
					begin
						by_int_r <= 1'b1;
						state_r <= SMC_START;
						unique case (mode_r)
							SMC_PDOWN, SMC_PSAVE:
								cnt_r <= startup_cycles;
							SMC_STBY, SMC_XSTBY:
								cnt_r <= {12'h0, SMC_STBY_WAKE};
							default: cnt_r <= 16'h0;
						endcase
					end
				SMC_START:
					if (cnt_r <= 16'h1)
					begin
						state_r <= SMC_STALL;
						cnt_r <= {12'h0, SMC_INT_STALL};
					end
					else
						cnt_r <= cnt_r - 16'h1;
				SMC_STALL:
					if (cnt_r <= 16'h1)
					begin
						state_r <= SMC_RUN;
						int_wake <= by_int_r;
						by_int_r <= 1'b0;
					end
					else
						cnt_r <= cnt_r - 16'h1;
			endcase
			if (wake_rst && state_r != SMC_SLEEP && state_r != SMC_RUN)
			begin
				state_r <= SMC_RUN;
				reset_wake <= 1'b1;
				// No handler run after a reset
				by_int_r <= 1'b0;
			end
		end
	end

	always_comb
	begin
		gate_nxt = '1;
		if (state_r == SMC_SLEEP)
		begin
			gate_nxt.core_clock = 1'b0;
			gate_nxt.program_memory_clock = 1'b0;
			gate_nxt.timer_osc = timer0_async_clocking;
			unique case (mode_r)
				SMC_IDLE: ;
				SMC_NOISE: gate_nxt.io_clock = 1'b0;
				SMC_PDOWN, SMC_STBY:
				begin
					gate_nxt.io_clock = 1'b0;
					gate_nxt.converter_clock = 1'b0;
					gate_nxt.async_clock = 1'b0;
					gate_nxt.timer_osc = 1'b0;
					gate_nxt.main_osc = (mode_r == SMC_STBY);
				end
				default:
				begin
					gate_nxt.io_clock = 1'b0;
					gate_nxt.converter_clock = 1'b0;
					gate_nxt.async_clock = timer0_async_clocking;
					gate_nxt.main_osc = (mode_r == SMC_XSTBY);
				end
			endcase
		end
		else if (state_r == SMC_START || state_r == SMC_STALL)
		begin
			// core held in stall
			// Oscillators settle while the core waits
			gate_nxt.core_clock = 1'b0;
			gate_nxt.program_memory_clock = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			clk_gate <= '1;
			adc_start <= 1'b0;
			async_undefined <= 1'b0;
		end
		else if (clk_en)
		begin
			clk_gate <= gate_nxt;
			adc_start <= go_sleep && state_r == SMC_RUN && adc_enabled
				&& (code == SMC_IDLE || code == SMC_NOISE);
			if (state_r == SMC_STALL && mode_r == SMC_PSAVE
				&& !timer0_async_clocking)
				async_undefined <= 1'b1;
			else if (go_sleep)
				async_undefined <= 1'b0;
		end
	end

	// Assertions
	a_no_sleep_se: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && state_r == SMC_RUN && sleep_instr
		&& !ctrl_r[SMC_SE_BIT] |=> state_r == SMC_RUN)
		else $error("Slept without sleep enable");
	a_rsv_code: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && state_r == SMC_RUN && (code == SMC_RSV4
		|| code == SMC_RSV5) |=> state_r == SMC_RUN)
		else $error("Reserved code entered sleep");
	a_stby_xtal: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && state_r == SMC_RUN && !crystal_selected
		&& code[2] |=> state_r == SMC_RUN)
		else $error("Standby without crystal");
	a_idle_core: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == SMC_SLEEP && mode_r == SMC_IDLE && $stable(state_r)
		|-> clk_gate.io_clock && !clk_gate.core_clock)
		else $error("Idle gating wrong");
	a_pdown_osc: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == SMC_SLEEP && mode_r == SMC_PDOWN && $stable(state_r)
		|-> !clk_gate.main_osc && !clk_gate.io_clock)
		else $error("Power-down oscillator running");
	a_adc_start: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && go_sleep && state_r == SMC_RUN && adc_enabled
		&& code == SMC_IDLE |=> adc_start)
		else $error("No conversion start on idle");
	sequence s_stby_wake;
		clk_en && state_r == SMC_SLEEP && mode_r == SMC_STBY
		&& wake_any && !wake_rst;
	endsequence
	a_stby_six: assert property (@(posedge ref_clk) disable iff (rst)
		s_stby_wake ##1 clk_en [*6] |=> state_r == SMC_STALL)
		else $error("Standby wake not in six cycles");
	a_stall_four: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && state_r == SMC_START && cnt_r <= 16'h1
		##1 clk_en [*4] |=> state_r == SMC_RUN)
		else $error("Stall not four cycles");
	a_stall_core: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == SMC_STALL && $past(state_r) == SMC_STALL
		|-> !clk_gate.core_clock)
		else $error("Core clock ran during stall");
	a_reset_wake: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && state_r == SMC_SLEEP && wake_rst
		|=> reset_wake && state_r == SMC_RUN)
		else $error("Reset did not wake");
	a_pdown_src: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && state_r == SMC_SLEEP && mode_r == SMC_PDOWN
		&& !wake_rst && wake_src == '0 |=> state_r == SMC_SLEEP)
		else $error("Power-down woke without source");

endmodule

// >>> tb/smc_core_model.sv
// Core and wake-source model facing the sleep controller
module smc_core_model
(
	// Clock and wake events
	input wire logic ref_clk,
	input wire logic int_wake,
	input wire logic reset_wake,
	// Core requests and sources
	output logic sleep_instr,
	output logic sleep_reset,
	output smc_pkg::smc_wake_t wake_src
);
	timeunit 1ns;
	timeprecision 1ns;
	import smc_pkg::*;

	initial
	begin
		sleep_instr = 1'b0;
		sleep_reset = 1'b0;
		wake_src = '0;
	end

	// One-cycle sleep, only issued while running
	task automatic sleep_op();
		@(posedge ref_clk);
		sleep_instr <= 1'b1;
		@(posedge ref_clk);
		sleep_instr <= 1'b0;
	endtask

	task automatic wake(input smc_wake_t w, input logic rw, input int lim,
		output int k);
		k = 0;
		@(posedge ref_clk);
		wake_src <= w;
		sleep_reset <= rw;
		do
		begin
			@(negedge ref_clk);
			k++;
		end
		while (int_wake !== 1'b1 && reset_wake !== 1'b1 && k < lim);
		@(posedge ref_clk);
		wake_src <= '0;
		sleep_reset <= 1'b0;
	endtask
endmodule

// >>> tb/tb_smc_sleep_ctrl.sv
// Self-checking bench for the sleep mode controller
module tb_smc_sleep_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import smc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic clk_en = 1'b1;
	logic gie = 1'b1;
	logic adc_en = 1'b1;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic sleep_instr, sleep_reset, int_wake, reset_wake;
	logic adc_start, async_undefined;
	logic as0 = 1'b0;
	logic xtal = 1'b0;
	smc_wake_t wake_src;
	smc_clk_t clk_gate;
	int n_fail = 0;
	int n_checks = 0;
	int n_adc = 0;
	int k, k0;
	logic [31:0] q;
	smc_mode_t md [6] = '{SMC_IDLE, SMC_NOISE, SMC_PDOWN, SMC_PSAVE,
		SMC_STBY, SMC_XSTBY};
	logic [6:0] gt [6] = '{7'h1e, 7'h0e, 7'h00, 7'h00, 7'h02, 7'h02};
	logic [16:0] bad [6] = '{17'h0, 17'h01100, 17'h17100, 17'h17100,
		17'h17100, 17'h17100};
	int su [6] = '{1, 1, 3, 3, 6, 6};
	logic [7:0] rf [5] = '{8'h08, 8'h30, 8'h34, 8'h38, 8'h3c};

	always #5 ref_clk = ~ref_clk;
	always @(negedge ref_clk)
		if (adc_start === 1'b1)
			n_adc++;

	smc_sleep_ctrl u_smc_sleep_ctrl
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.sleep_instr(sleep_instr),
		.sleep_reset(sleep_reset),
		.global_int_en(gie),
		.timer0_async_clocking(as0),
		.crystal_selected(xtal),
		.adc_enabled(adc_en),
		.startup_cycles(16'h0003),
		.wake_src(wake_src),
		.clk_gate(clk_gate),
		.adc_start(adc_start),
		.int_wake(int_wake),
		.reset_wake(reset_wake),
		.async_undefined(async_undefined)
	);

	smc_core_model u_smc_core_model
	(
		.ref_clk(ref_clk),
		.int_wake(int_wake),
		.reset_wake(reset_wake),
		.sleep_instr(sleep_instr),
		.sleep_reset(sleep_reset),
		.wake_src(wake_src)
	);

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	// Classic cycle; ack and data taken at the rising edge
	task automatic wb(input logic [3:0] a, input logic we,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		if (n >= 50)
		begin
			$display("Error wb ack expected 1 seen 0");
			n_fail++;
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic go(input logic [7:0] c);
		wb(SMC_ADDR_CTRL, 1'b1, {24'h0, c});
		u_smc_core_model.sleep_op();
		repeat (3) @(posedge ref_clk);
		wb(SMC_ADDR_STAT, 1'b0, 32'h0);
	endtask

	task automatic results();
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		results();
	end

	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		wb(SMC_ADDR_CTRL, 1'b0, 32'h0);
		chk("ctrl reset", {24'h0, SMC_CTRL_RST}, q);
		wb(4'h8, 1'b1, 32'hff);
		wb(4'h8, 1'b0, 32'h0);
		chk("unmapped", 32'h0, q);
		wb(SMC_ADDR_CTRL, 1'b1, 32'hff);
		wb(SMC_ADDR_CTRL, 1'b0, 32'h0);
		chk("ctrl rw", 32'hff, q);
		foreach (rf[i])
		begin
			go(rf[i]);
			chk("refused", 32'h0, {30'h0, q[1:0]});
			chk("gate run", 32'h7f, {25'h0, clk_gate});
		end
		xtal <= 1'b1;
		foreach (md[i])
		begin
			k0 = n_adc;
			go({2'b00, 1'b1, md[i], 2'b00});
			chk("status", {27'h0, md[i], 2'b01}, q);
			chk("gates", {25'h0, gt[i]}, {25'h0, clk_gate});
			chk("adc start", {31'h0, i < 2}, n_adc - k0);
			u_smc_core_model.wake(bad[i], 1'b0, 10, k);
			chk("no wake", 32'd10, k);
			u_smc_core_model.wake(17'h1, 1'b0, 300, k);
			n_checks++;
			if (k < su[i] + 5 || k > su[i] + 7)
			begin
				$display("Error latency expected %0d seen %0d", su[i] + 6, k);
				n_fail++;
			end
			repeat (2) @(posedge ref_clk);
			chk("gate awake", 32'h7f, {25'h0, clk_gate});
			if (md[i] == SMC_PSAVE)
				chk("async undef", 32'h1, {31'h0, async_undefined});
			wb(SMC_ADDR_CTRL, 1'b1, 32'h0);
		end
		as0 <= 1'b1;
		gie <= 1'b0;
		go(8'h2c);
		chk("psave gates", 32'h05, {25'h0, clk_gate});
		u_smc_core_model.wake(17'h04000, 1'b0, 10, k);
		chk("timer0 masked", 32'd10, k);
		gie <= 1'b1;
		u_smc_core_model.wake(17'h04000, 1'b0, 300, k);
		chk("timer0 wake", 32'h1, {31'h0, k < 300});
		chk("async defined", 32'h0, {31'h0, async_undefined});
		adc_en <= 1'b0;
		k0 = n_adc;
		go(8'h20);
		chk("adc disabled", 32'h0, n_adc - k0);
		clk_en <= 1'b0;
		u_smc_core_model.wake(17'h0, 1'b1, 5, k);
		chk("frozen", 32'd5, k);
		clk_en <= 1'b1;
		u_smc_core_model.wake(17'h0, 1'b1, 20, k);
		chk("reset wake", 32'h1, {31'h0, k < 5});
		wb(SMC_ADDR_STAT, 1'b0, 32'h0);
		chk("run after reset", 32'h0, {30'h0, q[1:0]});
		results();
	end
endmodule
